// File: rtl/control_pin_mux.sv
`timescale 1ns/1ps
module control_pin_mux (
  input  wire logic                             sys_clk,
  input  wire logic                             reset_n,
  input  wire logic                             testModeEnable,
  input  wire logic                             scanShiftEnable,
  input  wire logic                             crystalClockIn,
  input  wire logic                             hostSpiEnable,
  input  wire logic                             hostSpiMaster,
  input  wire logic                             displaySpiMaster,
  input  wire logic [pin_mux_pkg::PIN_COUNT-1:0] core0IoSelect,
  input  wire logic [pin_mux_pkg::PIN_COUNT-1:0] core0IoOut,
  input  wire logic [pin_mux_pkg::PIN_COUNT-1:0] core0IoOe,
  input  wire logic                             irqPinIoSelect,
  input  wire logic                             core1Io4Out,
  input  wire logic                             core1Io4Oe,
  input  wire logic                             twClkDriveLow,
  input  wire logic                             twDataDriveLow,
  input  wire logic                             hostMisoOut,
  input  wire logic                             hostMosiOut,
  input  wire logic                             displayMisoOut,
  input  wire logic                             displayMosiOut,
  input  wire logic                             dataServiceIrq,
  input  wire logic                             extIrqN,
  input  wire logic [pin_mux_pkg::PIN_COUNT-1:0] pinIn,
  input  wire logic                             irqPinIn,
  output logic      [pin_mux_pkg::PIN_COUNT-1:0] pinOut,
  output logic      [pin_mux_pkg::PIN_COUNT-1:0] pinOe,
  output logic                                  irqPinOut,
  output logic                                  irqPinOe,
  output logic      [pin_mux_pkg::PIN_COUNT-1:0] core0IoIn,
  output logic                                  core1Io4In,
  output logic                                  twClkIn,
  output logic                                  twDataIn,
  output logic                                  hostSckIn,
  output logic                                  hostMisoIn,
  output logic                                  hostMosiIn,
  output logic                                  hostSelIn,
  output logic                                  dispSckIn,
  output logic                                  dispSelIn,
  output logic                                  dispMisoIn,
  output logic                                  dispMosiIn,
  output logic                                  coreIrqReq,
  output logic                                  scanShift,
  output logic                                  crystalClkSel,
  output pin_mux_pkg::mode_type                  deviceMode
);
  import pin_mux_pkg::*;

  state_type state_q;
  state_type state_d;

  // the crystal input is only a clock to the clock tree; this block just steers its mux
  logic crystalUnused;
  assign crystalUnused = crystalClockIn;

  // next pin state; all pads are registered so a mode change shows one edge later
  always_comb begin
    state_d               = state_q;
    state_d.mode          = decode_mode(testModeEnable, scanShiftEnable);
    state_d.crystalClkSel = testModeEnable;
    state_d.scanShift     = testModeEnable && scanShiftEnable;
    state_d.coreIrqReq    = !extIrqN;
    state_d.pinOut        = PINS_RESET;
    state_d.pinOe         = PINS_RESET;
    // host clock: open-drain two-wire clock unless the serial bus owns it
    if (!hostSpiEnable) begin
      state_d.pinOe[HOST_CLK_PIN] = twClkDriveLow;
    end
    // host data: two-wire data, or serial slave output while selected
    if (!hostSpiEnable) begin
      state_d.pinOe[HOST_DATA_PIN] = twDataDriveLow;
    end else if (!hostSpiMaster) begin
      state_d.pinOut[HOST_DATA_PIN] = hostMisoOut;
      state_d.pinOe[HOST_DATA_PIN]  = !pinIn[HOST_SEL_PIN];        // released when deselected, bus is shared
    end
    // master-out pins drive only as master
    if (hostSpiEnable && hostSpiMaster) begin
      state_d.pinOut[HOST_MOSI_PIN] = hostMosiOut;
      state_d.pinOe[HOST_MOSI_PIN]  = BIT_SET;
    end
    if (displaySpiMaster) begin
      state_d.pinOut[DISP_MOSI_PIN] = displayMosiOut;
      state_d.pinOe[DISP_MOSI_PIN]  = BIT_SET;
    end else begin
      state_d.pinOut[DISP_MISO_PIN] = displayMisoOut;
      state_d.pinOe[DISP_MISO_PIN]  = !pinIn[DISP_SEL_PIN];
    end
    // first core takes over any pin it selects
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (core0IoSelect[i]) begin
        state_d.pinOut[i] = core0IoOut[i];
        state_d.pinOe[i]  = core0IoOe[i];
      end
    end
    // interrupt pin: interrupt to the main micro or second core I/O
    if (irqPinIoSelect) begin
      state_d.irqPinOut = core1Io4Out;
      state_d.irqPinOe  = core1Io4Oe;
    end else begin
      state_d.irqPinOut = dataServiceIrq;
      state_d.irqPinOe  = BIT_SET;
    end
    // input side: port A to first core, interrupt pin to second core
    state_d.core0IoIn  = pinIn;
    state_d.core1Io4In = irqPinIn;
    // engines see idle levels when the pin serves another function
    state_d.twClkIn    = (hostSpiEnable || core0IoSelect[HOST_CLK_PIN]) ? BIT_SET : pinIn[HOST_CLK_PIN];
    state_d.twDataIn   = (hostSpiEnable || core0IoSelect[HOST_DATA_PIN]) ? BIT_SET : pinIn[HOST_DATA_PIN];
    state_d.hostSckIn  = (hostSpiEnable && !core0IoSelect[HOST_CLK_PIN]) ? pinIn[HOST_CLK_PIN] : BIT_CLEAR;
    state_d.hostMisoIn = (hostSpiEnable && hostSpiMaster && !core0IoSelect[HOST_DATA_PIN]) ?
                         pinIn[HOST_DATA_PIN] : BIT_CLEAR;
    state_d.hostMosiIn = (hostSpiEnable && !hostSpiMaster && !core0IoSelect[HOST_MOSI_PIN]) ?
                         pinIn[HOST_MOSI_PIN] : BIT_CLEAR;
    state_d.hostSelIn  = (hostSpiEnable && !core0IoSelect[HOST_SEL_PIN]) ?
                         pinIn[HOST_SEL_PIN] : SELECT_IDLE;
    state_d.dispSckIn  = core0IoSelect[DISP_CLK_PIN] ? BIT_CLEAR : pinIn[DISP_CLK_PIN];
    state_d.dispSelIn  = core0IoSelect[DISP_SEL_PIN] ? SELECT_IDLE : pinIn[DISP_SEL_PIN];
    state_d.dispMisoIn = (displaySpiMaster && !core0IoSelect[DISP_MISO_PIN]) ?
                         pinIn[DISP_MISO_PIN] : BIT_CLEAR;
    state_d.dispMosiIn = (!displaySpiMaster && !core0IoSelect[DISP_MOSI_PIN]) ?
                         pinIn[DISP_MOSI_PIN] : BIT_CLEAR;
    // tri-state test overrides every output enable selected above
    if (state_d.mode == MODE_HIZ) begin
      state_d.pinOe    = PINS_RESET;
      state_d.irqPinOe = BIT_CLEAR;
    end
    if (!reset_n) begin
      state_d = STATE_RESET;
    end
  end

  // single state register
  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
  end

  // outputs straight from the state register
  assign pinOut        = state_q.pinOut;
  assign pinOe         = state_q.pinOe;
  assign irqPinOut     = state_q.irqPinOut;
  assign irqPinOe      = state_q.irqPinOe;
  assign core0IoIn     = state_q.core0IoIn;
  assign core1Io4In    = state_q.core1Io4In;
  assign twClkIn       = state_q.twClkIn;
  assign twDataIn      = state_q.twDataIn;
  assign hostSckIn     = state_q.hostSckIn;
  assign hostMisoIn    = state_q.hostMisoIn;
  assign hostMosiIn    = state_q.hostMosiIn;
  assign hostSelIn     = state_q.hostSelIn;
  assign dispSckIn     = state_q.dispSckIn;
  assign dispSelIn     = state_q.dispSelIn;
  assign dispMisoIn    = state_q.dispMisoIn;
  assign dispMosiIn    = state_q.dispMosiIn;
  assign coreIrqReq    = state_q.coreIrqReq;
  assign scanShift     = state_q.scanShift;
  assign crystalClkSel = state_q.crystalClkSel;
  assign deviceMode    = state_q.mode;

  // checks, one edge of latency everywhere
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic hizReq;
  assign hizReq = scanShiftEnable && !testModeEnable;

  crystal_clock_sel_a: assert property (testModeEnable |=> crystalClkSel && deviceMode != MODE_FUNC)
    else $error("crystal clock not selected in test mode");
  scan_shift_gate_a: assert property (scanShift |-> $past(testModeEnable) && $past(scanShiftEnable))
    else $error("scan shift without both test inputs");
  scan_hiz_all_a: assert property (hizReq |=> pinOe == PINS_RESET && !irqPinOe)
    else $error("pin driven during tri-state test");
  reset_default_a: assert property (disable iff (BIT_CLEAR)
    !reset_n |=> pinOe == PINS_RESET && !irqPinOe && deviceMode == MODE_FUNC && hostSelIn)
    else $error("pins not at default after reset");
  host_clk_input_a: assert property (hostSpiEnable && !core0IoSelect[HOST_CLK_PIN]
    |=> !pinOe[HOST_CLK_PIN] && hostSckIn == $past(pinIn[HOST_CLK_PIN]))
    else $error("host clock pin not a serial clock input");
  host_data_slave_a: assert property (hostSpiEnable && !hostSpiMaster && !core0IoSelect[HOST_DATA_PIN]
    && !pinIn[HOST_SEL_PIN] && !hizReq |=> pinOe[HOST_DATA_PIN] && pinOut[HOST_DATA_PIN] == $past(hostMisoOut))
    else $error("host slave data not driven");
  disp_mosi_master_a: assert property (displaySpiMaster && !core0IoSelect[DISP_MOSI_PIN] && !hizReq
    |=> pinOe[DISP_MOSI_PIN] && pinOut[DISP_MOSI_PIN] == $past(displayMosiOut))
    else $error("display master-out not driven");
  host_select_in_a: assert property (hostSpiEnable && !core0IoSelect[HOST_SEL_PIN]
    |=> !pinOe[HOST_SEL_PIN] && hostSelIn == $past(pinIn[HOST_SEL_PIN]))
    else $error("host select not followed");
  disp_miso_dir_a: assert property (displaySpiMaster && !core0IoSelect[DISP_MISO_PIN]
    |=> !pinOe[DISP_MISO_PIN] && dispMisoIn == $past(pinIn[DISP_MISO_PIN]))
    else $error("display master-in wrong direction");
  gpio_takeover_a: assert property (core0IoSelect[HOST_MOSI_PIN] && !hizReq
    |=> pinOe[HOST_MOSI_PIN] == $past(core0IoOe[HOST_MOSI_PIN])
        && pinOut[HOST_MOSI_PIN] == $past(core0IoOut[HOST_MOSI_PIN]))
    else $error("first core I/O not on pin");
  irq_pin_drive_a: assert property (!irqPinIoSelect && !hizReq
    |=> irqPinOe && irqPinOut == $past(dataServiceIrq))
    else $error("interrupt pin not driven");
  ext_irq_req_a: assert property ($fell(extIrqN) |=> coreIrqReq ##1 (coreIrqReq == !$past(extIrqN)))
    else $error("external interrupt not raised");

  scan_shift_c: cover property (testModeEnable && scanShiftEnable ##1 scanShift);
  hiz_entry_c: cover property (hizReq ##1 pinOe == PINS_RESET);
  host_slave_c: cover property (hostSpiEnable && !hostSpiMaster ##1 pinOe[HOST_DATA_PIN]);
  gpio_irq_c: cover property (irqPinIoSelect && core1Io4Oe ##1 irqPinOe);

endmodule // control_pin_mux

// File: rtl/pin_mux_pkg.sv
package pin_mux_pkg;

  // shared control pins, host port first, display port after
  localparam int PIN_COUNT     = 8;
  localparam int HOST_CLK_PIN  = 0;
  localparam int HOST_DATA_PIN = 1;
  localparam int HOST_MOSI_PIN = 2;
  localparam int HOST_SEL_PIN  = 3;
  localparam int DISP_CLK_PIN  = 4;
  localparam int DISP_MISO_PIN = 5;
  localparam int DISP_MOSI_PIN = 6;
  localparam int DISP_SEL_PIN  = 7;

  // reset levels
  localparam logic [PIN_COUNT-1:0] PINS_RESET  = 8'h00;
  localparam logic                 BIT_CLEAR   = 1'h0;
  localparam logic                 BIT_SET     = 1'h1;
  localparam logic                 SELECT_IDLE = 1'h1;

  // device operating mode
  typedef enum logic [3:0] {
    MODE_FUNC = 4'h1,
    MODE_TEST = 4'h2,
    MODE_SCAN = 4'h4,
    MODE_HIZ  = 4'h8
  } mode_type;

  typedef struct packed {
    mode_type             mode;
    logic [PIN_COUNT-1:0] pinOut;
    logic [PIN_COUNT-1:0] pinOe;
    logic                 irqPinOut;
    logic                 irqPinOe;
    logic [PIN_COUNT-1:0] core0IoIn;
    logic                 core1Io4In;
    logic                 twClkIn;
    logic                 twDataIn;
    logic                 hostSckIn;
    logic                 hostMisoIn;
    logic                 hostMosiIn;
    logic                 hostSelIn;
    logic                 dispSckIn;
    logic                 dispSelIn;
    logic                 dispMisoIn;
    logic                 dispMosiIn;
    logic                 coreIrqReq;
    logic                 scanShift;
    logic                 crystalClkSel;
  } state_type;

  localparam state_type STATE_RESET = '{
    mode:      MODE_FUNC,
    twClkIn:   BIT_SET,
    twDataIn:  BIT_SET,
    hostSelIn: SELECT_IDLE,
    dispSelIn: SELECT_IDLE,
    default:   BIT_CLEAR
  };

  // test strap decode into the one-hot operating mode; the tri-state strap alone wins over functional mode only
  function automatic mode_type decode_mode(input logic test_mode_enable, input logic scanEn);
    if (test_mode_enable && scanEn) begin
      return MODE_SCAN;
    end else if (test_mode_enable) begin
      return MODE_TEST;
    end else if (scanEn) begin
      return MODE_HIZ;
    end else begin
      return MODE_FUNC;
    end
  endfunction

endpackage

// File: sim/control_micro_model.sv
`timescale 1ns/1ps
// far side: main and display micros on the shared pins, seen as pad levels
module control_micro_model
  import pin_mux_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic [PIN_COUNT-1:0] pinOut,
  input  wire logic [PIN_COUNT-1:0] pinOe,
  input  wire logic                 irqPinOut,
  input  wire logic                 irqPinOe,
  input  wire logic [PIN_COUNT-1:0] farVal,
  input  wire logic [PIN_COUNT-1:0] farEn,
  input  wire logic                 irqFarVal,
  input  wire logic                 irqFarEn,
  output logic      [PIN_COUNT-1:0] pinIn,
  output logic                      irqPinIn
);
  logic idle_q = 1'h0;

  // released lines other than pins 0 and 1 wander every cycle so a stale level never passes for a live one
  always @(posedge sys_clk) begin
    idle_q <= !idle_q;
  end

  // device drive wins over the micro; two-wire pins 0 and 1 float to their pull-up
  always_comb begin
    for (int n = 0; n < PIN_COUNT; n++) begin
      if (pinOe[n]) begin
        pinIn[n] = pinOut[n];
      end else if (farEn[n]) begin
        pinIn[n] = farVal[n];
      end else if (n < 2) begin
        pinIn[n] = 1'b1;
      end else begin
        pinIn[n] = idle_q ^ n[0];
      end
    end
    irqPinIn = irqPinOe ? irqPinOut : (irqFarEn ? irqFarVal : idle_q);
  end
endmodule // control_micro_model

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pin_mux_pkg::*;
  logic                 sys_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 testModeEnable, scanShiftEnable, crystalClockIn, hostSpiEnable, hostSpiMaster;
  logic                 displaySpiMaster, irqPinIoSelect, core1Io4Out, core1Io4Oe, twClkDriveLow;
  logic                 twDataDriveLow, hostMisoOut, hostMosiOut, displayMisoOut, displayMosiOut;
  logic                 dataServiceIrq, extIrqN, irqPinIn, irqFarVal, irqFarEn, expValid_q = 1'h0;
  logic [PIN_COUNT-1:0] core0IoSelect, core0IoOut, core0IoOe, pinIn, farVal, farEn;
  logic [PIN_COUNT-1:0] pinOut, pinOe, core0IoIn;
  logic                 irqPinOut, irqPinOe, core1Io4In, twClkIn, twDataIn, hostSckIn, hostMisoIn;
  logic                 hostMosiIn, hostSelIn, dispSckIn, dispSelIn, dispMisoIn, dispMosiIn;
  logic                 coreIrqReq, scanShift, crystalClkSel;
  mode_type             deviceMode;
  state_type            exp_q;
  int                   nErrors = 0, samplesChecked = 0, cycles = 0;

  control_pin_mux dut (.sys_clk, .reset_n, .testModeEnable, .scanShiftEnable, .crystalClockIn, .hostSpiEnable,
    .hostSpiMaster, .displaySpiMaster, .core0IoSelect, .core0IoOut, .core0IoOe, .irqPinIoSelect, .core1Io4Out,
    .core1Io4Oe, .twClkDriveLow, .twDataDriveLow, .hostMisoOut, .hostMosiOut, .displayMisoOut, .displayMosiOut,
    .dataServiceIrq, .extIrqN, .pinIn, .irqPinIn, .pinOut, .pinOe, .irqPinOut, .irqPinOe, .core0IoIn, .core1Io4In,
    .twClkIn, .twDataIn, .hostSckIn, .hostMisoIn, .hostMosiIn, .hostSelIn, .dispSckIn, .dispSelIn, .dispMisoIn,
    .dispMosiIn, .coreIrqReq, .scanShift, .crystalClkSel, .deviceMode);
  control_micro_model far (.sys_clk, .pinOut, .pinOe, .irqPinOut, .irqPinOe, .farVal, .farEn, .irqFarVal,
    .irqFarEn, .pinIn, .irqPinIn);

  always #10 sys_clk = ~sys_clk;

  // what the pins must show one edge after the inputs seen at this edge
  function automatic state_type predict();
    state_type            e;
    logic                 two;
    logic [PIN_COUNT-1:0] u;
    e = STATE_RESET;
    two = !hostSpiEnable;
    u = ~core0IoSelect;
    if (reset_n) begin
      e.mode = mode_type'({scanShiftEnable & !testModeEnable, scanShiftEnable & testModeEnable,
                           testModeEnable & !scanShiftEnable, !testModeEnable & !scanShiftEnable});
      e.pinOe = {1'b0, displaySpiMaster, !displaySpiMaster & !pinIn[7], 2'b00, hostSpiEnable & hostSpiMaster,
                 two ? twDataDriveLow : !hostSpiMaster & !pinIn[3], two & twClkDriveLow};
      e.pinOut = {1'b0, displayMosiOut, displayMisoOut, 2'b00, hostMosiOut, !two & hostMisoOut, 1'b0};
      e.pinOe = (e.pinOe & u) | (core0IoOe & core0IoSelect);
      e.irqPinOe = irqPinIoSelect ? core1Io4Oe : 1'b1;
      // the tri-state strap beats every select, io ones included
      if (scanShiftEnable && !testModeEnable) begin
        e.pinOe = 8'h00;
        e.irqPinOe = 1'b0;
      end
      e.pinOut = ((e.pinOut & u) | (core0IoOut & core0IoSelect)) & e.pinOe;
      e.irqPinOut = (irqPinIoSelect ? core1Io4Out : dataServiceIrq) & e.irqPinOe;
      e.core0IoIn = pinIn;
      e.core1Io4In = irqPinIn;
      e.twClkIn = (two & u[0]) ? pinIn[0] : 1'b1;
      e.twDataIn = (two & u[1]) ? pinIn[1] : 1'b1;
      e.hostSckIn = hostSpiEnable & u[0] & pinIn[0];
      e.hostMisoIn = hostSpiEnable & hostSpiMaster & u[1] & pinIn[1];
      e.hostMosiIn = hostSpiEnable & !hostSpiMaster & u[2] & pinIn[2];
      e.hostSelIn = (hostSpiEnable & u[3]) ? pinIn[3] : 1'b1;
      e.dispSckIn = u[4] & pinIn[4];
      e.dispMisoIn = displaySpiMaster & u[5] & pinIn[5];
      e.dispMosiIn = !displaySpiMaster & u[6] & pinIn[6];
      e.dispSelIn = u[7] ? pinIn[7] : 1'b1;
      e.coreIrqReq = !extIrqN;
      e.scanShift = testModeEnable & scanShiftEnable;
      e.crystalClkSel = testModeEnable;
    end
    return e;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // random levels on every input but reset_n, straps kept rare so functional muxing gets most cycles
  task automatic drive_random();
    {hostSpiEnable, hostSpiMaster, displaySpiMaster, irqPinIoSelect} <= 4'($urandom);
    {core1Io4Out, core1Io4Oe, twClkDriveLow, twDataDriveLow, crystalClockIn} <= 5'($urandom);
    {hostMisoOut, hostMosiOut, displayMisoOut, displayMosiOut, dataServiceIrq, extIrqN} <= 6'($urandom);
    {core0IoSelect, core0IoOut, core0IoOe} <= {8'($urandom) & 8'($urandom), 16'($urandom)};
    {farVal, farEn, irqFarVal, irqFarEn} <= 18'($urandom);
    testModeEnable <= ($urandom % 6 == 0);
    scanShiftEnable <= ($urandom % 6 == 0);
  endtask

  // expectation taken at the edge, compared at the falling edge once outputs settled
  always @(posedge sys_clk) begin
    exp_q <= predict();
    expValid_q <= 1'h1;
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      report_and_stop();
    end
  end

  always @(negedge sys_clk) begin
    if (expValid_q) begin
      check(deviceMode, exp_q.mode);
      check(pinOe, exp_q.pinOe);
      check(pinOut & pinOe, exp_q.pinOut);
      check({irqPinOe, irqPinOut & irqPinOe, core1Io4In}, {exp_q.irqPinOe, exp_q.irqPinOut, exp_q.core1Io4In});
      check(core0IoIn, exp_q.core0IoIn);
      check({twClkIn, twDataIn, hostSckIn}, {exp_q.twClkIn, exp_q.twDataIn, exp_q.hostSckIn});
      check({hostMisoIn, hostMosiIn, hostSelIn}, {exp_q.hostMisoIn, exp_q.hostMosiIn, exp_q.hostSelIn});
      check({dispSckIn, dispSelIn}, {exp_q.dispSckIn, exp_q.dispSelIn});
      check({dispMisoIn, dispMosiIn}, {exp_q.dispMisoIn, exp_q.dispMosiIn});
      check({scanShift, crystalClkSel}, {exp_q.scanShift, exp_q.crystalClkSel});
      check(coreIrqReq, exp_q.coreIrqReq);
    end
  end

  // main sequence: walk example, strap corners over full io drive, then random with mid-run resets
  initial begin
    void'($urandom(22621));
    {testModeEnable, scanShiftEnable, crystalClockIn, hostSpiEnable, hostSpiMaster, displaySpiMaster} = '0;
    {irqPinIoSelect, core1Io4Out, core1Io4Oe, twClkDriveLow, twDataDriveLow, hostMisoOut, hostMosiOut} = '0;
    {displayMisoOut, displayMosiOut, dataServiceIrq, irqFarVal, irqFarEn} = '0;
    {core0IoSelect, core0IoOut, core0IoOe, farVal, farEn} = '0;
    extIrqN = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    hostSpiEnable <= 1'b1;
    hostMisoOut <= 1'b1;
    farEn <= 8'h08;
    @(posedge sys_clk);
    scanShiftEnable <= 1'b1;
    @(posedge sys_clk);
    {core0IoSelect, core0IoOe, irqPinIoSelect, core1Io4Oe} <= {16'hffff, 2'b11};
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      {testModeEnable, scanShiftEnable} <= 2'(k);
    end
    for (int i = 0; i < 2000; i++) begin
      @(posedge sys_clk);
      drive_random();
      reset_n <= (i % 400 > 1);
    end
    repeat (2) @(posedge sys_clk);
    report_and_stop();
  end
endmodule // tb_top
